// >>> core/sad_defs.vh
// address map and timing constants for the system address decoder
`ifndef SAD_DEFS_VH
`define SAD_DEFS_VH

`define SAD_FLASH0_BASE     32'h00000000
`define SAD_FLASH0_LAST     32'h0003FFFF
`define SAD_FLASH1_BASE     32'h00040000
`define SAD_FLASH1_LAST     32'h0007FFFF
`define SAD_BROM_BASE       32'h08000000
`define SAD_BROM_LAST       32'h08000FFF
`define SAD_SRAM_BASE       32'h10000000
`define SAD_SRAM_LAST       32'h1000FFFF
`define SAD_CODE_LAST       32'h1FFFFFFF
`define SAD_APB_BASE        32'h40000000
`define SAD_APB_LAST        32'h4FFFFFFF
`define SAD_AHBP_BASE       32'h50000000
`define SAD_AHBP_LAST       32'h5FFFFFFF
`define SAD_PPR_BASE        32'hE0000000
`define SAD_PPR_LAST        32'hE00FFFFF

// peripheral slot: 4 KB slot, register window 1 KB inside it
`define SAD_SLOT_MSB        31
`define SAD_SLOT_LSB        12
`define SAD_SLOT_W          20
`define SAD_REG_MSB         11
`define SAD_REG_LSB         2
`define SAD_REG_W           10
`define SAD_IMPL_W          10'h0FF

// apb slot numbers (address bits 31:12)
`define SAD_SLOT_RSTBOD     20'h40000
`define SAD_SLOT_CLKRTC     20'h40004
`define SAD_SLOT_TIMER      20'h40008
`define SAD_SLOT_VCOMP      20'h4000C
`define SAD_SLOT_GPIO       20'h40010
`define SAD_SLOT_UART       20'h4001C
`define SAD_SLOT_MISC       20'h40020
`define SAD_SLOT_WDT        20'h40024
// ahb slot numbers
`define SAD_SLOT_SSLV       20'h50000
`define SAD_SLOT_SMST0      20'h50004
`define SAD_SLOT_SMST1      20'h50005
`define SAD_SLOT_ADC        20'h50008
`define SAD_SLOT_INFO       20'h50020
`define SAD_OTP_BASE        32'h50020400
`define SAD_OTP_LAST        32'h500207FF

// target codes
`define SAD_TW              4
`define SAD_T_HOLE          4'h0
`define SAD_T_FLASH0        4'h1
`define SAD_T_FLASH1        4'h2
`define SAD_T_BROM          4'h3
`define SAD_T_SRAM          4'h4
`define SAD_T_APB           4'h5
`define SAD_T_AHBP          4'h6
`define SAD_T_PPR           4'h7

// peripheral select vectors
`define SAD_NAPB            8
`define SAD_NAHB            6

// htrans nonseq/seq bit, hresp okay
`define SAD_HTRANS_ACT      1
`define SAD_HRESP_OKAY      1'h0
`define SAD_ZERO32          32'h00000000
`define SAD_APB_WAITS       2'h1

`endif

// >>> core/sad_region_decode.v
// address to target decoder for one bus master
`include "sad_defs.vh"

module sad_region_decode (
    // address in
    input  wire [31:0]          addr,
    // decoded target
    output reg  [`SAD_TW-1:0]   target
);

    function in_range;
        input [31:0] a;
        input [31:0] lo;
        input [31:0] hi;
        begin
            in_range = (a >= lo) && (a <= hi);
        end
    endfunction

    always @* begin
        if (in_range(addr, `SAD_FLASH0_BASE, `SAD_FLASH0_LAST)) begin
            target = `SAD_T_FLASH0;
        end else if (in_range(addr, `SAD_FLASH1_BASE, `SAD_FLASH1_LAST)) begin
            target = `SAD_T_FLASH1;
        end else if (in_range(addr, `SAD_BROM_BASE, `SAD_BROM_LAST)) begin
            target = `SAD_T_BROM;
        end else if (in_range(addr, `SAD_SRAM_BASE, `SAD_SRAM_LAST)) begin
            target = `SAD_T_SRAM;
        end else if (in_range(addr, `SAD_APB_BASE, `SAD_APB_LAST)) begin
            target = `SAD_T_APB;
        end else if (in_range(addr, `SAD_AHBP_BASE, `SAD_AHBP_LAST)) begin
            target = `SAD_T_AHBP;
        end else if (in_range(addr, `SAD_PPR_BASE, `SAD_PPR_LAST)) begin
            target = `SAD_T_PPR;
        end else begin
            target = `SAD_T_HOLE;
        end
    end

endmodule // sad_region_decode

// >>> core/sad_periph_decode.v
// peripheral slot decoder for the apb and ahb peripheral regions
`include "sad_defs.vh"

module sad_periph_decode (
    // address in
    input  wire [31:0]          addr,
    // slot selects
    output reg  [`SAD_NAPB-1:0] apb_sel,
    output reg  [`SAD_NAHB-1:0] ahb_sel,
    output wire                 hit
);

    wire [`SAD_SLOT_W-1:0] slot;
    assign slot = addr[`SAD_SLOT_MSB:`SAD_SLOT_LSB];

    always @* begin
        apb_sel = {`SAD_NAPB{1'b0}};
        ahb_sel = {`SAD_NAHB{1'b0}};
        case (slot)
            `SAD_SLOT_RSTBOD: apb_sel[0] = 1'b1;
            `SAD_SLOT_CLKRTC: apb_sel[1] = 1'b1;
            `SAD_SLOT_TIMER:  apb_sel[2] = 1'b1;
            `SAD_SLOT_VCOMP:  apb_sel[3] = 1'b1;
            `SAD_SLOT_GPIO:   apb_sel[4] = 1'b1;
            `SAD_SLOT_UART:   apb_sel[5] = 1'b1;
            `SAD_SLOT_MISC:   apb_sel[6] = 1'b1;
            `SAD_SLOT_WDT:    apb_sel[7] = 1'b1;
            `SAD_SLOT_SSLV:   ahb_sel[0] = 1'b1;
            `SAD_SLOT_SMST0:  ahb_sel[1] = 1'b1;
            `SAD_SLOT_SMST1:  ahb_sel[2] = 1'b1;
            `SAD_SLOT_ADC:    ahb_sel[3] = 1'b1;
            `SAD_SLOT_INFO: begin
                if (addr >= `SAD_OTP_BASE && addr <= `SAD_OTP_LAST) begin
                    ahb_sel[5] = 1'b1;
                end else if (addr < `SAD_OTP_BASE) begin
                    ahb_sel[4] = 1'b1;
                end
            end
            default: ;
        endcase
    end

    assign hit = (|apb_sel) | (|ahb_sel);

endmodule // sad_periph_decode

// >>> core/sad_decoder.v
// system address decoder and bus fabric: three masters, memories, peripherals
`include "sad_defs.vh"

module sad_decoder (
    // clock and reset
    input  wire                 clock,
    input  wire                 sys_rst,
    input  wire                 clk_en,
    // instruction bus master
    input  wire [31:0]          i_haddr,
    input  wire [1:0]           i_htrans,
    output reg                  i_hready,
    output reg  [31:0]          i_hrdata,
    output reg                  i_hresp,
    // data and debug bus master
    input  wire [31:0]          d_haddr,
    input  wire [1:0]           d_htrans,
    input  wire                 d_hwrite,
    input  wire [31:0]          d_hwdata,
    output reg                  d_hready,
    output reg  [31:0]          d_hrdata,
    output reg                  d_hresp,
    // system bus master
    input  wire [31:0]          s_haddr,
    input  wire [1:0]           s_htrans,
    input  wire                 s_hwrite,
    input  wire [31:0]          s_hwdata,
    output reg                  s_hready,
    output reg  [31:0]          s_hrdata,
    output reg                  s_hresp,
    // read data returned by each target
    input  wire [31:0]          flash0_rdata,
    input  wire [31:0]          flash1_rdata,
    input  wire [31:0]          brom_rdata,
    input  wire [31:0]          sram_rdata,
    input  wire [31:0]          apb_rdata,
    input  wire [31:0]          ahbp_rdata,
    input  wire [31:0]          ppr_rdata,
    // strobes towards memories and peripherals
    output reg                  flash0_sel,
    output reg                  flash1_sel,
    output reg                  brom_sel,
    output reg                  sram_sel,
    output reg                  ppr_sel,
    output reg  [`SAD_NAPB-1:0] apb_sel,
    output reg  [`SAD_NAHB-1:0] ahbp_sel,
    output reg                  tgt_write,
    output reg  [31:0]          tgt_wdata,
    output reg  [`SAD_REG_W-1:0] tgt_reg_index
);

    // bus state machine for the shared target side
    localparam ST_IDLE = 2'h0;
    localparam ST_WAIT = 2'h1;
    localparam ST_DATA = 2'h2;

    reg  [1:0]          state;
    reg  [1:0]          next_state;
    reg  [1:0]          waits;
    reg  [1:0]          owner;
    reg  [`SAD_TW-1:0]  cur_tgt;
    reg                 cur_write;

    wire [`SAD_TW-1:0]  i_tgt;
    wire [`SAD_TW-1:0]  d_tgt;
    wire [`SAD_TW-1:0]  s_tgt;
    wire [`SAD_NAPB-1:0] s_apb;
    wire [`SAD_NAHB-1:0] s_ahb;
    wire                s_phit;

    function is_code;
        input [`SAD_TW-1:0] t;
        begin
            is_code = (t == `SAD_T_FLASH0) || (t == `SAD_T_FLASH1) ||
                      (t == `SAD_T_BROM) || (t == `SAD_T_SRAM);
        end
    endfunction

    function [31:0] pick_data;
        input [`SAD_TW-1:0] t;
        input [31:0] f0;
        input [31:0] f1;
        input [31:0] br;
        input [31:0] sr;
        input [31:0] ap;
        input [31:0] ah;
        input [31:0] pp;
        begin
            case (t)
                `SAD_T_FLASH0: pick_data = f0;
                `SAD_T_FLASH1: pick_data = f1;
                `SAD_T_BROM:   pick_data = br;
                `SAD_T_SRAM:   pick_data = sr;
                `SAD_T_APB:    pick_data = ap;
                `SAD_T_AHBP:   pick_data = ah;
                `SAD_T_PPR:    pick_data = pp;
                default:       pick_data = `SAD_ZERO32;
            endcase
        end
    endfunction

    sad_region_decode u_i_dec (
        .addr   (i_haddr),
        .target (i_tgt)
    );

    sad_region_decode u_d_dec (
        .addr   (d_haddr),
        .target (d_tgt)
    );

    sad_region_decode u_s_dec (
        .addr   (s_haddr),
        .target (s_tgt)
    );

    sad_periph_decode u_p_dec (
        .addr    (s_haddr),
        .apb_sel (s_apb),
        .ahb_sel (s_ahb),
        .hit     (s_phit)
    );

    wire i_req = i_htrans[`SAD_HTRANS_ACT] && is_code(i_tgt);
    wire d_req = d_htrans[`SAD_HTRANS_ACT] && is_code(d_tgt);
    wire s_req = s_htrans[`SAD_HTRANS_ACT];
    wire s_periph = (s_tgt == `SAD_T_APB) || (s_tgt == `SAD_T_AHBP);
    wire s_is_apb = (s_tgt == `SAD_T_APB) && s_phit;
    wire s_is_ahb = (s_tgt == `SAD_T_AHBP) && s_phit;
    // unused slots inside the peripheral regions are holes too
    wire [`SAD_TW-1:0] s_eff = (s_periph && !s_phit) ? `SAD_T_HOLE : s_tgt;

    // fixed priority: data bus, then instruction bus, then system bus
    always @* begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (d_req || i_req) begin
                    next_state = ST_DATA;
                end else if (s_req && s_is_apb) begin
                    next_state = ST_WAIT;
                end else if (s_req) begin
                    next_state = ST_DATA;
                end
            end
            ST_WAIT: begin
                // leave after one wait cycle so the bridge adds exactly one
                if (waits == `SAD_APB_WAITS - 2'h1) begin
                    next_state = ST_DATA;
                end
            end
            ST_DATA: next_state = ST_IDLE;
            default: next_state = ST_IDLE;
        endcase
    end

    always @(posedge clock) begin
        if (sys_rst) begin
            state         <= ST_IDLE;
            waits         <= 2'h0;
            owner         <= 2'h0;
            cur_tgt       <= `SAD_T_HOLE;
            cur_write     <= 1'b0;
            i_hready      <= 1'b1;
            d_hready      <= 1'b1;
            s_hready      <= 1'b1;
            i_hrdata      <= `SAD_ZERO32;
            d_hrdata      <= `SAD_ZERO32;
            s_hrdata      <= `SAD_ZERO32;
            i_hresp       <= `SAD_HRESP_OKAY;
            d_hresp       <= `SAD_HRESP_OKAY;
            s_hresp       <= `SAD_HRESP_OKAY;
            flash0_sel    <= 1'b0;
            flash1_sel    <= 1'b0;
            brom_sel      <= 1'b0;
            sram_sel      <= 1'b0;
            ppr_sel       <= 1'b0;
            apb_sel       <= {`SAD_NAPB{1'b0}};
            ahbp_sel      <= {`SAD_NAHB{1'b0}};
            tgt_write     <= 1'b0;
            tgt_wdata     <= `SAD_ZERO32;
            tgt_reg_index <= {`SAD_REG_W{1'b0}};
        end else if (clk_en) begin
            state <= next_state;
            // responses are always okay, writes never error
            i_hresp <= `SAD_HRESP_OKAY;
            d_hresp <= `SAD_HRESP_OKAY;
            s_hresp <= `SAD_HRESP_OKAY;
            case (state)
                ST_IDLE: begin
                    waits <= 2'h0;
                    if (d_req || i_req || s_req) begin
                        // a losing master is stalled until it is granted
                        i_hready <= !i_req;
                        d_hready <= !d_req;
                        s_hready <= !s_req;
                    end else begin
                        i_hready <= 1'b1;
                        d_hready <= 1'b1;
                        s_hready <= 1'b1;
                    end
                    if (d_req || i_req || s_req) begin
                        owner     <= d_req ? 2'h1 : (i_req ? 2'h0 : 2'h2);
                        cur_tgt   <= d_req ? d_tgt : (i_req ? i_tgt : s_eff);
                        cur_write <= d_req ? d_hwrite : (i_req ? 1'b0 : s_hwrite);
                        flash0_sel <= (d_req ? d_tgt : (i_req ? i_tgt : s_eff)) == `SAD_T_FLASH0;
                        flash1_sel <= (d_req ? d_tgt : (i_req ? i_tgt : s_eff)) == `SAD_T_FLASH1;
                        brom_sel   <= (d_req ? d_tgt : (i_req ? i_tgt : s_eff)) == `SAD_T_BROM;
                        sram_sel   <= (d_req ? d_tgt : (i_req ? i_tgt : s_eff)) == `SAD_T_SRAM;
                        ppr_sel    <= !(d_req || i_req) && (s_eff == `SAD_T_PPR);
                        apb_sel    <= (!(d_req || i_req) && s_is_apb) ? s_apb : {`SAD_NAPB{1'b0}};
                        ahbp_sel   <= (!(d_req || i_req) && s_is_ahb) ? s_ahb : {`SAD_NAHB{1'b0}};
                        tgt_write  <= d_req ? d_hwrite : (i_req ? 1'b0 : s_hwrite);
                        tgt_reg_index <= d_req ? d_haddr[`SAD_REG_MSB:`SAD_REG_LSB] :
                                         (i_req ? i_haddr[`SAD_REG_MSB:`SAD_REG_LSB] :
                                          s_haddr[`SAD_REG_MSB:`SAD_REG_LSB]);
                        // hole writes are dropped: tgt_write is raised but no target select
                        tgt_wdata  <= d_req ? d_hwdata : s_hwdata;
                    end
                end
                ST_WAIT: begin
                    waits <= waits + 2'h1;
                end
                ST_DATA: begin
                    flash0_sel <= 1'b0;
                    flash1_sel <= 1'b0;
                    brom_sel   <= 1'b0;
                    sram_sel   <= 1'b0;
                    ppr_sel    <= 1'b0;
                    apb_sel    <= {`SAD_NAPB{1'b0}};
                    ahbp_sel   <= {`SAD_NAHB{1'b0}};
                    tgt_write  <= 1'b0;
                    // read data passes through; unimplemented registers are not forced
                    case (owner)
                        2'h0: begin
                            i_hrdata <= pick_data(cur_tgt, flash0_rdata, flash1_rdata, brom_rdata,
                                                  sram_rdata, apb_rdata, ahbp_rdata, ppr_rdata);
                            i_hready <= 1'b1;
                        end
                        2'h1: begin
                            d_hrdata <= cur_write ? d_hrdata :
                                        pick_data(cur_tgt, flash0_rdata, flash1_rdata, brom_rdata,
                                                  sram_rdata, apb_rdata, ahbp_rdata, ppr_rdata);
                            d_hready <= 1'b1;
                        end
                        default: begin
                            s_hrdata <= cur_write ? s_hrdata :
                                        pick_data(cur_tgt, flash0_rdata, flash1_rdata, brom_rdata,
                                                  sram_rdata, apb_rdata, ahbp_rdata, ppr_rdata);
                            s_hready <= 1'b1;
                        end
                    endcase
                end
                default: ;
            endcase
        end
    end

endmodule // sad_decoder

// >>> sim/sad_target_model.sv
// read data model of the memories and peripherals behind the decoder
module sad_target_model (
    // selects and register index
    input  wire logic        flash0_sel,
    input  wire logic        flash1_sel,
    input  wire logic        brom_sel,
    input  wire logic        sram_sel,
    input  wire logic        ppr_sel,
    input  wire logic [7:0]  apb_sel,
    input  wire logic [5:0]  ahbp_sel,
    input  wire logic [9:0]  tgt_reg_index,
    // read data back
    output logic      [31:0] flash0_rdata,
    output logic      [31:0] flash1_rdata,
    output logic      [31:0] brom_rdata,
    output logic      [31:0] sram_rdata,
    output logic      [31:0] apb_rdata,
    output logic      [31:0] ahbp_rdata,
    output logic      [31:0] ppr_rdata
);
    timeunit 1ns;
    timeprecision 1ns;
    // stateless: writes change nothing, unselected targets show the inverse word
    function automatic logic [31:0] pat(logic s, logic [7:0] c, logic [13:0] m, logic [9:0] ix);
        pat = s ? {c, m, ix} : ~{c, m, ix};
    endfunction
    assign flash0_rdata = pat(flash0_sel, 8'hC1, 14'h0000, tgt_reg_index);
    assign flash1_rdata = pat(flash1_sel, 8'hC2, 14'h0000, tgt_reg_index);
    assign brom_rdata   = pat(brom_sel, 8'hC3, 14'h0000, tgt_reg_index);
    assign sram_rdata   = pat(sram_sel, 8'hC4, 14'h0000, tgt_reg_index);
    assign ppr_rdata    = pat(ppr_sel, 8'hC7, 14'h0000, tgt_reg_index);
    // any register index answers with some word, no defined value needed
    assign apb_rdata    = pat(|apb_sel, 8'hA0, {apb_sel, 6'h00}, tgt_reg_index);
    assign ahbp_rdata   = pat(|ahbp_sel, 8'hB0, {2'h0, ahbp_sel, 6'h00}, tgt_reg_index);
endmodule // sad_target_model

// >>> sim/sad_decoder_monitor.sv
// concurrent checks on the decoder ports
module sad_decoder_monitor (
    // clock and reset
    input  wire logic        clock,
    input  wire logic        sys_rst,
    input  wire logic        clk_en,
    // master requests and answers
    input  wire logic [31:0] i_haddr,
    input  wire logic [1:0]  i_htrans,
    input  wire logic        i_hready,
    input  wire logic        i_hresp,
    input  wire logic [31:0] d_haddr,
    input  wire logic [1:0]  d_htrans,
    input  wire logic        d_hready,
    input  wire logic        d_hresp,
    input  wire logic [31:0] s_haddr,
    input  wire logic [1:0]  s_htrans,
    input  wire logic        s_hready,
    input  wire logic        s_hresp,
    // target selects
    input  wire logic        flash0_sel,
    input  wire logic        flash1_sel,
    input  wire logic        brom_sel,
    input  wire logic        sram_sel,
    input  wire logic        ppr_sel,
    input  wire logic [7:0]  apb_sel,
    input  wire logic [5:0]  ahbp_sel
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);
    wire logic any_sel = flash0_sel | flash1_sel | brom_sel | sram_sel | ppr_sel | (|apb_sel) | (|ahbp_sel);
    wire logic d_req = clk_en && d_htrans[1] && d_hready;
    wire logic i_req = clk_en && i_htrans[1] && i_hready && !d_htrans[1];
    wire logic s_req = clk_en && s_htrans[1] && s_hready && !d_htrans[1] && !i_htrans[1];
    function automatic logic in_r(logic [31:0] a, lo, hi);
        in_r = a >= lo && a <= hi;
    endfunction
    sequence fast_done(sel, rdy);
        sel && !rdy ##[1:2] rdy;
    endsequence
    sequence gpio_done;
        (apb_sel == 8'h10 && !s_hready) [*2] ##1 s_hready;
    endsequence
    chk_resp_always_okay: assert property (!i_hresp && !d_hresp && !s_hresp)
        else $error("error response seen");
    chk_flash0_route: assert property (d_req && in_r(d_haddr, 32'h00000000, 32'h0003FFFF) |=> fast_done(flash0_sel, d_hready))
        else $error("flash 0 access wrong");
    chk_flash1_route: assert property (i_req && in_r(i_haddr, 32'h00040000, 32'h0007FFFF) |=> fast_done(flash1_sel, i_hready))
        else $error("flash 1 access wrong");
    chk_brom_route: assert property (d_req && in_r(d_haddr, 32'h08000000, 32'h08000FFF) |=> fast_done(brom_sel, d_hready))
        else $error("boot rom access wrong");
    chk_sram_route: assert property (s_req && in_r(s_haddr, 32'h10000000, 32'h1000FFFF) |=> fast_done(sram_sel, s_hready))
        else $error("sram access wrong");
    chk_apb_wait_state: assert property (s_req && in_r(s_haddr, 32'h40010000, 32'h400103FF) |=> gpio_done)
        else $error("apb access timing wrong");
    chk_ahb_adc_route: assert property (s_req && in_r(s_haddr, 32'h50008000, 32'h500083FF) |=> fast_done(ahbp_sel == 6'h08, s_hready))
        else $error("ahb peripheral access wrong");
    chk_ppr_route: assert property (s_req && in_r(s_haddr, 32'hE0000000, 32'hE00FFFFF) |=> fast_done(ppr_sel, s_hready))
        else $error("private region access wrong");
    chk_hole_no_sel: assert property (s_req && in_r(s_haddr, 32'h60000000, 32'hDFFFFFFF) |=> !any_sel [*3])
        else $error("hole raised a select");
    chk_ifetch_ignored: assert property (i_req && !s_htrans[1] && i_haddr > 32'h1FFFFFFF |=> !any_sel && i_hready)
        else $error("instruction bus served outside code");
    chk_slot_onehot: assert property ($onehot0(apb_sel) && $onehot0(ahbp_sel))
        else $error("slot select not one-hot");
endmodule // sad_decoder_monitor

bind sad_decoder sad_decoder_monitor sad_decoder_monitor_inst (.*);

// >>> sim/tb.sv
// self-checking bench for the system address decoder
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int FAST = 1;
    localparam int SLOW = 2;
    logic clock = 0, sys_rst = 1, clk_en = 1, d_hwrite = 0, s_hwrite = 0;
    logic [31:0] i_haddr = 0, d_haddr = 0, s_haddr = 0, d_hwdata = 0, s_hwdata = 0;
    logic [1:0] i_htrans = 0, d_htrans = 0, s_htrans = 0;
    wire logic i_hready, d_hready, s_hready, i_hresp, d_hresp, s_hresp, tgt_write;
    wire logic flash0_sel, flash1_sel, brom_sel, sram_sel, ppr_sel;
    wire logic [31:0] i_hrdata, d_hrdata, s_hrdata, tgt_wdata, flash0_rdata, flash1_rdata;
    wire logic [31:0] brom_rdata, sram_rdata, apb_rdata, ahbp_rdata, ppr_rdata;
    wire logic [7:0] apb_sel;
    wire logic [5:0] ahbp_sel;
    wire logic [9:0] tgt_reg_index;
    wire logic any_sel = flash0_sel | flash1_sel | brom_sel | sram_sel | ppr_sel | (|apb_sel) | (|ahbp_sel);
    int miscompares = 0, checks = 0, cycles = 0, lat;
    logic [31:0] rd, wseen;
    logic seen_sel, seen_wr;
    sad_decoder sad_decoder_inst (.*);
    sad_target_model sad_target_model_inst (.*);
    always #50 clock = ~clock;
    task automatic tally_and_finish;
        if (miscompares == 0 && checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    always @(posedge clock) begin
        cycles++;
        if (cycles == 5000) begin
            miscompares++;
            tally_and_finish;
        end
    end
    task automatic cmp(string what, logic [31:0] exp, logic [31:0] got);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    // one single-word transfer on master m: 0 instruction, 1 data, 2 system
    task automatic xfer(int m, logic [31:0] a, logic w, logic [31:0] wd);
        logic rdy;
        @(negedge clock);
        if (m == 0) begin
            i_haddr = a;
            i_htrans = 2'h2;
        end else if (m == 1) begin
            {d_haddr, d_hwrite, d_hwdata, d_htrans} = {a, w, wd, 2'h2};
        end else begin
            {s_haddr, s_hwrite, s_hwdata, s_htrans} = {a, w, wd, 2'h2};
        end
        @(negedge clock);
        {seen_sel, seen_wr} = 2'h0;
        if (any_sel === 1'b1) begin
            {seen_sel, seen_wr, wseen} = {1'b1, tgt_write, tgt_wdata};
        end
        {i_htrans, d_htrans, s_htrans} = 6'h00;
        for (lat = 1; lat < 20; lat++) begin
            @(posedge clock);
            #1;
            if (any_sel === 1'b1) begin
                {seen_sel, seen_wr, wseen} = {1'b1, tgt_write, tgt_wdata};
            end
            rdy = (m == 0) ? i_hready : (m == 1) ? d_hready : s_hready;
            if (rdy === 1'b1) break;
        end
        rd = (m == 0) ? i_hrdata : (m == 1) ? d_hrdata : s_hrdata;
        cmp("hresp", 32'h0, {i_hresp, d_hresp, s_hresp});
        repeat (2) @(posedge clock);
    endtask
    task automatic t_code;
        logic [31:0] a [0:5];
        logic [7:0] c [0:5];
        a = '{32'h00000000, 32'h0003FFFC, 32'h00040000, 32'h0007FFFC, 32'h08000FFC, 32'h1000FFFC};
        c = '{8'hC1, 8'hC1, 8'hC2, 8'hC2, 8'hC3, 8'hC4};
        for (int k = 0; k < 6; k++) begin
            for (int m = 0; m < 2; m++) begin
                xfer(m, a[k], 1'b0, 32'h0);
                cmp("code read", {c[k], 14'h0000, a[k][11:2]}, rd);
                cmp("code latency", FAST, lat);
            end
        end
    endtask
    task automatic t_ignore;
        xfer(0, 32'h40010000, 1'b0, 32'h0);
        cmp("fetch outside code select", 32'h0, seen_sel);
        xfer(1, 32'h50008000, 1'b1, 32'h12345678);
        cmp("data bus outside code select", 32'h0, seen_sel);
    endtask
    task automatic t_holes;
        logic [31:0] a [0:8];
        a = '{32'h00080000, 32'h08001000, 32'h10010000, 32'h40001000, 32'h4FFFFFFC,
              32'h50020800, 32'h60000000, 32'hE0100000, 32'hF0000FFC};
        for (int k = 0; k < 9; k++) begin
            xfer(2, a[k], 1'b0, 32'h0);
            cmp("hole read", 32'h0, rd);
            xfer(2, a[k], 1'b1, 32'hFFFFFFFF);
            cmp("hole select", 32'h0, seen_sel);
        end
    endtask
    task automatic t_apb;
        logic [31:0] a [0:7];
        a = '{32'h400001FC, 32'h400041FC, 32'h400081FC, 32'h4000C1FC,
              32'h400101FC, 32'h4001C1FC, 32'h400201FC, 32'h400241FC};
        for (int k = 0; k < 8; k++) begin
            xfer(2, a[k], 1'b0, 32'h0);
            cmp("apb read", {8'hA0, 8'h01 << k, 6'h00, a[k][11:2]}, rd);
            cmp("apb latency", SLOW, lat);
        end
    endtask
    task automatic t_ahbp;
        logic [31:0] a [0:5];
        a = '{32'h500003FC, 32'h500043FC, 32'h500053FC, 32'h500083FC, 32'h500203FC, 32'h500207FC};
        for (int k = 0; k < 6; k++) begin
            xfer(2, a[k], 1'b0, 32'h0);
            cmp("ahb read", {8'hB0, 2'h0, 6'h01 << k, 6'h00, a[k][11:2]}, rd);
            cmp("ahb latency", FAST, lat);
        end
    endtask
    task automatic t_sys;
        xfer(2, 32'hE0000E80, 1'b0, 32'h0);
        cmp("private region read", {8'hC7, 14'h0000, 10'h3A0}, rd);
        xfer(2, 32'h10000010, 1'b0, 32'h0);
        cmp("system sram read", {8'hC4, 14'h0000, 10'h004}, rd);
    endtask
    task automatic t_writes;
        xfer(2, 32'h40010004, 1'b1, 32'hA5A55A5A);
        cmp("apb write strobe", 32'h1, seen_wr);
        cmp("apb write data", 32'hA5A55A5A, wseen);
        cmp("apb write latency", SLOW, lat);
        xfer(2, 32'h50020010, 1'b1, 32'h0F0F00FF);
        cmp("read-only write strobe", 32'h1, seen_wr);
        cmp("read-only write latency", FAST, lat);
        xfer(2, 32'h50020010, 1'b0, 32'h0);
        cmp("read-only read back", {8'hB0, 2'h0, 6'h10, 6'h00, 10'h004}, rd);
    endtask
    // clock enable low for three cycles during an apb access stretches it by three
    task automatic t_freeze;
        fork
            xfer(2, 32'h400081FC, 1'b0, 32'h0);
            begin
                repeat (2) @(negedge clock);
                clk_en = 0;
                repeat (3) @(negedge clock);
                clk_en = 1;
            end
        join
        cmp("frozen apb latency", SLOW + 3, lat);
        cmp("frozen apb read", {8'hA0, 8'h04, 6'h00, 10'h07F}, rd);
    endtask
    initial begin
        repeat (2) @(posedge clock);
        @(negedge clock);
        sys_rst = 0;
        t_code;
        t_ignore;
        t_holes;
        t_apb;
        t_ahbp;
        t_sys;
        t_writes;
        t_freeze;
        tally_and_finish;
    end
endmodule // tb
